//--- logic/rivm_pkg.sv
// Purpose: Constants and carriers for the reset and interrupt vector map
// Assumes: One system clock; vector numbers 1..17, word addresses
// Notes:   Shared by the vector map and its checks
//
// Notes on behaviour
// R1: Every reset kind targets word zero normally
// R2: External requests map to 001, 002, 00D
// R3: Timer vectors at 003..007 and 00E
// R4: Serial vectors at 008 through 00B
// R5: Comparator 00C, nvm 00F, store 010
// R6: Programmed boot fuse moves reset to boot
// R7: Vector select adds boot start to vectors
// R8: Fuse and select decode independently
// R9: Only enabled sources are ever dispatched
// R10: Change enable self-clears after four cycles
// R11: Dispatch blocked during change sequence
// R12: Lowest pending vector number wins
package rivm_pkg;

  // ****************************************
  // Sizes and table constants
  // ****************************************
  localparam int          RIVM_ADDR_W        = 12;
  localparam int          RIVM_NUM_SRC       = 16;
  localparam int          RIVM_NUM_W         = 5;
  localparam logic [11:0] RIVM_RESET_ADDR    = 12'h000;
  localparam logic [11:0] RIVM_TABLE_START   = 12'h001;
  localparam logic [4:0]  RIVM_FIRST_IRQ_NUM = 5'h02;
  localparam int          RIVM_CHANGE_CYC    = 4;
  localparam logic        RIVM_FUSE_PROG     = 1'b0;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic vectorSelect;
    logic changeEnable;
  } rivm_ctrl_s;

  typedef struct packed {
    logic        valid;
    logic [4:0]  num;
    logic [11:0] addr;
  } rivm_vec_s;

  typedef enum logic [1:0] {
    RIVM_IDLE,
    RIVM_ARMED,
    RIVM_POST_WRITE
  } rivm_seq_e;

endpackage

//--- logic/rivm_top.sv
// Purpose: Reset target and prioritised interrupt vector for the core
// Assumes: Requests, control writes and instruction ends on this clock
// Notes:   Fuse level and boot start come from outside; fuse is synchronised
`timescale 1ns/1ps
`default_nettype none
module rivm_top #(
  parameter int ADDR_W  = rivm_pkg::RIVM_ADDR_W,
  parameter int NUM_SRC = rivm_pkg::RIVM_NUM_SRC
) (
  input  wire logic                 clock,
  input  wire logic                 sys_rst,
  input  wire logic [NUM_SRC-1:0]   srcPending,
  input  wire logic [NUM_SRC-1:0]   srcEnable,
  input  wire logic                 globalIrqEnable,
  input  wire logic                 bootResetFuse,
  input  wire logic [ADDR_W-1:0]    bootStartAddr,
  input  wire logic                 ctrlWrite,
  input  wire rivm_pkg::rivm_ctrl_s ctrlData,
  input  wire logic                 instrDone,
  output var  logic [ADDR_W-1:0]    resetVector_q,
  output var  rivm_pkg::rivm_vec_s  irqVector_q,
  output var  logic                 vectorSelect_q,
  output var  logic                 changeEnable_q,
  output var  logic                 dispatchBlocked_q
);
  import rivm_pkg::*;

  // ****************************************
  // Fuse synchroniser
  // ****************************************
  logic fuseMeta_q;
  logic fuseSync_q;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      fuseMeta_q <= 1'b1;
      fuseSync_q <= 1'b1;
    end else begin
      fuseMeta_q <= bootResetFuse;
      fuseSync_q <= fuseMeta_q;
    end
  end

  // ****************************************
  // Reset target
  // ****************************************
  // Reset vector decoded apart from the table base
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      resetVector_q <= ADDR_W'(RIVM_RESET_ADDR);
    end else if (fuseSync_q == RIVM_FUSE_PROG) begin
      resetVector_q <= bootStartAddr; // [R6] [R8]
    end else begin
      resetVector_q <= ADDR_W'(RIVM_RESET_ADDR); // [R1] [R8]
    end
  end

  // ****************************************
  // Timed change sequence
  // ****************************************
  rivm_seq_e seq_q;
  logic [2:0] winCnt_q;
  logic selWrite;
  logic blockNow;

  // A write with change enable low only counts inside the window
  assign selWrite = ctrlWrite && !ctrlData.changeEnable && changeEnable_q;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      changeEnable_q <= 1'b0;
      winCnt_q       <= 3'h0;
    end else if (ctrlWrite && ctrlData.changeEnable) begin
      changeEnable_q <= 1'b1;
      winCnt_q       <= 3'(RIVM_CHANGE_CYC - 1);
    end else if (selWrite || winCnt_q == 3'h0) begin
      changeEnable_q <= 1'b0; // [R10]
      winCnt_q       <= 3'h0;
    end else begin
      winCnt_q       <= winCnt_q - 3'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      vectorSelect_q <= 1'b0;
    end else if (selWrite) begin
      vectorSelect_q <= ctrlData.vectorSelect; // [R10]
    end
  end

  // Global enable is never touched; blocking is a separate gate
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      seq_q <= RIVM_IDLE;
    end else begin
      unique case (seq_q)
        RIVM_IDLE: begin
          if (ctrlWrite && ctrlData.changeEnable) begin
            seq_q <= RIVM_ARMED; // [R11]
          end
        end
        RIVM_ARMED: begin
          if (selWrite) begin
            seq_q <= RIVM_POST_WRITE;
          end else if (!(ctrlWrite && ctrlData.changeEnable) && winCnt_q == 3'h0) begin
            seq_q <= RIVM_IDLE; // [R11]
          end
        end
        RIVM_POST_WRITE: begin
          // A fresh arm here must not fall through to idle
          if (ctrlWrite && ctrlData.changeEnable) begin
            seq_q <= RIVM_ARMED; // [R11]
          end else if (instrDone) begin
            seq_q <= RIVM_IDLE; // [R11]
          end
        end
      endcase
    end
  end

  assign blockNow = (seq_q != RIVM_IDLE) || (ctrlWrite && ctrlData.changeEnable); // [R11]

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      dispatchBlocked_q <= 1'b0;
    end else begin
      dispatchBlocked_q <= blockNow;
    end
  end

  // ****************************************
  // Priority and address
  // ****************************************
  logic [NUM_SRC-1:0] live;
  logic               anyLive;
  logic [4:0]         winIdx;
  logic [ADDR_W-1:0]  tableBase;

  assign live = srcPending & srcEnable; // [R9]

  // Scan downward so the lowest number is the last to win
  always_comb begin
    anyLive = 1'b0;
    winIdx  = 5'h00;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (live[i]) begin
        anyLive = 1'b1; // [R12]
        winIdx  = 5'(i);
      end
    end
  end

  // Vector n sits at word n-1; vector select adds the boot start
  assign tableBase = vectorSelect_q ? bootStartAddr : ADDR_W'(RIVM_RESET_ADDR); // [R7] [R8]

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irqVector_q <= '0;
    end else begin
      irqVector_q.valid <= anyLive && globalIrqEnable && !blockNow; // [R9] [R11]
      irqVector_q.num   <= winIdx + RIVM_FIRST_IRQ_NUM;
      irqVector_q.addr  <= tableBase + ADDR_W'(RIVM_TABLE_START) + ADDR_W'(winIdx); // [R2] [R3] [R4] [R5]
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_reset_vec_plain: assert property (!$past(sys_rst) && $past(fuseSync_q) |->  // [R1]
    resetVector_q == ADDR_W'(RIVM_RESET_ADDR)) else $error("reset vector not zero");
  a_reset_vec_boot: assert property (!$past(sys_rst) && !$past(fuseSync_q) |->  // [R6]
    resetVector_q == $past(bootStartAddr)) else $error("reset vector not boot start");
  a_ext_zero_addr: assert property (irqVector_q.valid && irqVector_q.num == 5'h02 |->  // [R2]
    irqVector_q.addr == ($past(vectorSelect_q) ? $past(bootStartAddr) : '0) + ADDR_W'(12'h001))
    else $error("ext request zero address wrong");
  a_ext_two_addr: assert property (irqVector_q.valid && irqVector_q.num == 5'h0E |->  // [R2]
    irqVector_q.addr == ($past(vectorSelect_q) ? $past(bootStartAddr) : '0) + ADDR_W'(12'h00D))
    else $error("ext request two address wrong");
  a_timer_match_addr: assert property (!vectorSelect_q && !$past(vectorSelect_q) ##1  // [R3]
    irqVector_q.valid && irqVector_q.num == 5'h0F |-> irqVector_q.addr == ADDR_W'(12'h00E))
    else $error("narrow timer match address wrong");
  a_serial_addr: assert property (irqVector_q.valid && irqVector_q.num == 5'h0B && !$past(vectorSelect_q) |->  // [R4]
    irqVector_q.addr == ADDR_W'(12'h00A)) else $error("tx empty address wrong");
  a_store_ready_addr: assert property (irqVector_q.valid && irqVector_q.num == 5'h11 && !$past(vectorSelect_q) |->  // [R5]
    irqVector_q.addr == ADDR_W'(12'h010)) else $error("store ready address wrong");
  a_relocated_offset: assert property (irqVector_q.valid && $past(vectorSelect_q) |->  // [R7]
    irqVector_q.addr - $past(bootStartAddr) == ADDR_W'(irqVector_q.num - 5'h01))
    else $error("relocated vector offset wrong");
  a_enabled_only: assert property (irqVector_q.valid |->  // [R9]
    (($past(srcPending & srcEnable) >> (irqVector_q.num - 5'h02)) & NUM_SRC'(1)) != '0)
    else $error("vector for disabled source");
  a_change_window: assert property ($rose(changeEnable_q) && !ctrlWrite ##1 !ctrlWrite [*3] |=>  // [R10]
    !changeEnable_q) else $error("change enable held too long");
  a_change_holds: assert property ($rose(changeEnable_q) && !ctrlWrite ##1 !ctrlWrite ##1 !ctrlWrite
    |=> changeEnable_q) else $error("change enable cleared early"); // [R10]
  a_block_on_arm: assert property (ctrlWrite && ctrlData.changeEnable |=>  // [R11]
    !irqVector_q.valid [*2]) else $error("dispatch during change sequence");
  a_lowest_first: assert property (irqVector_q.valid |->  // [R12]
    (($past(live) << 1) & ((17'h00001 << (irqVector_q.num - 5'h01)) - 17'h00001)) == '0)
    else $error("lower pending vector skipped");

  // Control bit updates, the enable and block gates, and the plain table
  a_select_applies: assert property (selWrite |=>  // [R10]
    vectorSelect_q == $past(ctrlData.vectorSelect) && !changeEnable_q) else $error("select write not applied");
  a_refused_write: assert property (ctrlWrite && !ctrlData.changeEnable && !changeEnable_q |=>  // [R10]
    vectorSelect_q == $past(vectorSelect_q)) else $error("select changed outside window");
  a_global_gate: assert property (!globalIrqEnable |=> !irqVector_q.valid)  // [R9]
    else $error("dispatch with global enable off");
  a_rearm_blocks: assert property (seq_q == RIVM_POST_WRITE && ctrlWrite && ctrlData.changeEnable |=>  // [R11]
    seq_q == RIVM_ARMED) else $error("arm lost after select write");
  a_block_ends: assert property (seq_q == RIVM_IDLE && !ctrlWrite && globalIrqEnable &&  // [R11]
    (|(srcPending & srcEnable)) |=> irqVector_q.valid) else $error("dispatch held after sequence");
  a_plain_table: assert property (irqVector_q.valid && !$past(vectorSelect_q) |->  // [R8]
    irqVector_q.addr == ADDR_W'(irqVector_q.num - 5'h01)) else $error("plain table address wrong");

  c_relocated_irq: cover property (vectorSelect_q ##1 irqVector_q.valid);
  c_rearm_after_write: cover property (seq_q == RIVM_POST_WRITE && ctrlWrite && ctrlData.changeEnable);
  c_select_write: cover property (ctrlWrite && ctrlData.changeEnable ##[1:4] selWrite);
  c_window_expires: cover property ($rose(changeEnable_q) ##4 !changeEnable_q && seq_q == RIVM_IDLE);
  c_boot_reset: cover property (resetVector_q != '0);

endmodule
`default_nettype wire

//--- test/rivm_core_model.sv
// Purpose: Fetch side model taking dispatched vectors
// Assumes: An instruction ends every third cycle
// Notes:   Keeps the last dispatched address
`timescale 1ns/1ps
`default_nettype none
module rivm_core_model (
  input  wire logic                clock,
  input  wire logic                sys_rst,
  input  wire rivm_pkg::rivm_vec_s irqVector_q,
  output var  logic                instrDone,
  output var  logic [11:0]         fetchAddr_q
);
  import rivm_pkg::*;
  logic [1:0] phase_q;
  // Fixed cadence so block release timing is reproducible
  always_ff @(posedge clock) begin
    phase_q <= (sys_rst || phase_q == 2'h2) ? 2'h0 : phase_q + 2'h1;
  end
  assign instrDone = (phase_q == 2'h2);
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      fetchAddr_q <= 12'h000;
    end else if (irqVector_q.valid) begin
      fetchAddr_q <= irqVector_q.addr;
    end
  end
endmodule
`default_nettype wire

//--- test/tb.sv
// Purpose: Self-checking bench for the vector map
// Assumes: Inputs driven 1 ns after the rising edge
// Notes:   Boot start fixed at C00
`timescale 1ns/1ps
`default_nettype none
module tb;
  import rivm_pkg::*;
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic [15:0] srcPending = 16'h0000;
  logic [15:0] srcEnable = 16'hFFFF;
  logic        globalIrqEnable = 1'b1;
  logic        bootResetFuse = 1'b1;
  logic [11:0] bootStartAddr = 12'hC00;
  logic        ctrlWrite = 1'b0;
  rivm_ctrl_s  ctrlData = '0;
  logic        instrDone, vectorSelect_q, changeEnable_q, dispatchBlocked_q;
  logic [11:0] resetVector_q, fetchAddr_q;
  rivm_vec_s   irqVector_q;
  int          n_fail = 0;
  int          compares = 0;
  always #2.5 clock = ~clock;
  rivm_top i_rivm_top (.clock(clock), .sys_rst(sys_rst), .srcPending(srcPending),
    .srcEnable(srcEnable), .globalIrqEnable(globalIrqEnable), .bootResetFuse(bootResetFuse),
    .bootStartAddr(bootStartAddr), .ctrlWrite(ctrlWrite), .ctrlData(ctrlData),
    .instrDone(instrDone), .resetVector_q(resetVector_q), .irqVector_q(irqVector_q),
    .vectorSelect_q(vectorSelect_q), .changeEnable_q(changeEnable_q), .dispatchBlocked_q(dispatchBlocked_q));
  rivm_core_model i_rivm_core_model (.clock(clock), .sys_rst(sys_rst),
    .irqVector_q(irqVector_q), .instrDone(instrDone), .fetchAddr_q(fetchAddr_q));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input logic [17:0] got, input logic [17:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic ctl(input logic vs, input logic ce);
    ctrlWrite = 1'b1;
    ctrlData = '{vs, ce};
    tick(1);
    ctrlWrite = 1'b0;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_reset();
    chk(resetVector_q, 18'h0, "reset unprog");
    bootResetFuse = 1'b0;
    tick(4);
    chk(resetVector_q, 18'hC00, "reset prog");
    bootResetFuse = 1'b1;
    tick(4);
    chk(resetVector_q, 18'h0, "reset back");
    $display("test_reset done");
  endtask
  task automatic test_table();
    for (int i = 0; i < 16; i++) begin
      srcPending = 16'h0001 << i;
      tick(1);
      chk(irqVector_q, {1'b1, 5'(i + 2), 12'(i + 1)}, "vector");
    end
    srcPending = 16'hA000;
    tick(1);
    chk(irqVector_q, {1'b1, 5'h0F, 12'h00E}, "prio");
    srcPending = 16'hFFFF;
    tick(1);
    chk(irqVector_q, {1'b1, 5'h02, 12'h001}, "prio all");
    srcEnable = 16'h0000;
    tick(1);
    chk(18'(irqVector_q.valid), 18'h0, "disabled");
    srcEnable = 16'hFFFF;
    globalIrqEnable = 1'b0;
    tick(1);
    chk(18'(irqVector_q.valid), 18'h0, "global off");
    globalIrqEnable = 1'b1;
    srcPending = 16'h0001;
    tick(1);
    $display("test_table done");
  endtask
  task automatic test_move();
    ctl(1'b0, 1'b1);
    tick(1);
    chk(18'(changeEnable_q), 18'h1, "ce set");
    chk(18'(irqVector_q.valid), 18'h0, "blocked");
    chk(18'(dispatchBlocked_q), 18'h1, "flag set");
    ctl(1'b1, 1'b0);
    tick(1);
    chk({vectorSelect_q, changeEnable_q}, 18'h2, "select");
    chk(18'(irqVector_q.valid), 18'h0, "still blocked");
    // Release waits for the next instruction end
    for (int k = 0; k < 10 && irqVector_q.valid !== 1'b1; k++) tick(1);
    chk(irqVector_q, {1'b1, 5'h02, 12'hC01}, "moved");
    tick(1);
    chk(fetchAddr_q, 18'hC01, "fetch");
    $display("test_move done");
  endtask
  task automatic test_expire();
    ctl(1'b0, 1'b1);
    tick(3);
    chk(18'(changeEnable_q), 18'h1, "ce c4");
    tick(1);
    chk(18'(changeEnable_q), 18'h0, "ce c5");
    chk(18'(irqVector_q.valid), 18'h0, "block c5");
    chk(18'(dispatchBlocked_q), 18'h1, "flag c5");
    tick(1);
    chk(irqVector_q, {1'b1, 5'h02, 12'hC01}, "unblocked");
    chk(18'(dispatchBlocked_q), 18'h0, "flag clear");
    ctl(1'b0, 1'b0);
    tick(1);
    chk(18'(vectorSelect_q), 18'h1, "refused");
    bootResetFuse = 1'b0;
    tick(3);
    chk(resetVector_q, 18'hC00, "both moved");
    chk(irqVector_q, {1'b1, 5'h02, 12'hC01}, "both table");
    bootResetFuse = 1'b1;
    $display("test_expire done");
  endtask
  task automatic finish_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    tick(12);
    sys_rst = 1'b0;
    tick(3);
    test_reset();
    test_table();
    test_move();
    test_expire();
    finish_test();
  end
  // Run needs about 65 cycles; generous margin
  initial begin
    #20000;
    n_fail++;
    finish_test();
  end
endmodule
`default_nettype wire
